// File: rtl/eip_top.sv
// External interrupt pair: configuration register plus two channels.
// Assumes a simple byte register port decoded by address, one-cycle strobes.
`timescale 1ns/10ps
`include "eip_consts.svh"
module eip_top
    import eip_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // Register port
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    // Sense selects from the timer control register (edge=1)
    input  wire logic       i_irq_a_edge_sel,
    input  wire logic       i_irq_b_edge_sel,
    // Processor vectoring acknowledges, one-cycle pulses
    input  wire logic       i_irq_a_vector,
    input  wire logic       i_irq_b_vector,
    // Port 0 pins
    input  wire logic [7:0] i_port0,
    // Outputs
    output logic [7:0]      o_reg_rdata,
    output logic            o_irq_a_pending,
    output logic            o_irq_b_pending
);
    logic [7:0] ext_irq_config;   // Configuration register
    logic [7:0] next_rdata;       // Read mux
    logic       pend_a;
    logic       pend_b;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ext_irq_config <= `EIP_CFG_RESET;
        end else if (i_reg_wr && i_reg_addr == `EIP_CFG_ADDR) begin
            ext_irq_config <= i_reg_wdata;
        end
    end

    // Registered read; unmapped addresses read zero
    always_comb begin
        next_rdata = (i_reg_addr == `EIP_CFG_ADDR) ? ext_irq_config : 8'h00;
    end
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= next_rdata;
        end
    end

    eip_channel u_chan_a (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_port0      (i_port0),
        .i_pin_sel    (ext_irq_config[`EIP_A_SEL_MSB:`EIP_A_SEL_LSB]),
        .i_polarity   (ext_irq_config[`EIP_A_POL_BIT]),
        .i_edge_sel   (i_irq_a_edge_sel),
        .i_vector_ack (i_irq_a_vector),
        .o_pending    (pend_a)
    );
    eip_channel u_chan_b (
        .i_clock      (i_clock),
        .i_rst        (i_rst),
        .i_port0      (i_port0),
        .i_pin_sel    (ext_irq_config[`EIP_B_SEL_MSB:`EIP_B_SEL_LSB]),
        .i_polarity   (ext_irq_config[`EIP_B_POL_BIT]),
        .i_edge_sel   (i_irq_b_edge_sel),
        .i_vector_ack (i_irq_b_vector),
        .o_pending    (pend_b)
    );

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_irq_a_pending <= 1'b0;
            o_irq_b_pending <= 1'b0;
        end else begin
            o_irq_a_pending <= pend_a;
            o_irq_b_pending <= pend_b;
        end
    end

    // Assertion helpers
    logic act_a;
    assign act_a = ext_irq_config[`EIP_A_POL_BIT] ? u_chan_a.raw_lvl : ~u_chan_a.raw_lvl;

    property p_reset_cfg;
        @(posedge i_clock) i_rst |=> ext_irq_config == `EIP_CFG_RESET;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("config not reset");

    property p_write_cfg;
        @(posedge i_clock) disable iff (i_rst)
        (i_reg_wr && i_reg_addr == `EIP_CFG_ADDR) |=> ext_irq_config == $past(i_reg_wdata);
    endproperty
    a_write_cfg: assert property (p_write_cfg) else $error("config write lost");

    property p_level_track;
        @(posedge i_clock) disable iff (i_rst)
        (!i_irq_a_edge_sel) |=> pend_a == $past(act_a);
    endproperty
    a_level_track: assert property (p_level_track) else $error("level pending wrong");

    sequence s_rise_a;
        i_irq_a_edge_sel && u_chan_a.active && !u_chan_a.act_prev;
    endsequence
    property p_edge_set;
        @(posedge i_clock) disable iff (i_rst) s_rise_a |=> pend_a ##1 o_irq_a_pending;
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge not latched");

    property p_vector_clr;
        @(posedge i_clock) disable iff (i_rst)
        (i_irq_a_edge_sel && i_irq_a_vector && !(u_chan_a.active && !u_chan_a.act_prev)) |=> !pend_a;
    endproperty
    a_vector_clr: assert property (p_vector_clr) else $error("vector clear failed");

    property p_edge_hold;
        @(posedge i_clock) disable iff (i_rst)
        (i_irq_a_edge_sel && pend_a && !i_irq_a_vector) |=> pend_a;
    endproperty
    a_edge_hold: assert property (p_edge_hold) else $error("edge pending dropped");

    property p_out_follow;
        @(posedge i_clock) disable iff (i_rst) 1'b1 |=> o_irq_b_pending == $past(pend_b);
    endproperty
    a_out_follow: assert property (p_out_follow) else $error("request not pending");

    property p_rdata;
        @(posedge i_clock) disable iff (i_rst)
        (i_reg_addr == `EIP_CFG_ADDR) |=> o_reg_rdata == $past(ext_irq_config);
    endproperty
    a_rdata: assert property (p_rdata) else $error("readback wrong");

    // Independent view of each selected pin: agreed stages, polarity applied.
    // Built from the sync stages so these checks do not reuse the channel's own mux.
    eip_sel_t   sel_a;        // First pin code
    eip_sel_t   sel_b;        // Second pin code
    logic       agree_a;      // Stages two and three agree, first pin
    logic       agree_b;      // Stages two and three agree, second pin
    logic       lvl_a;        // Agreed first pin, high when active
    logic       lvl_b;        // Agreed second pin, high when active
    assign sel_a   = ext_irq_config[`EIP_A_SEL_MSB:`EIP_A_SEL_LSB];
    assign sel_b   = ext_irq_config[`EIP_B_SEL_MSB:`EIP_B_SEL_LSB];
    assign agree_a = u_chan_a.sync2[sel_a] == u_chan_a.sync3[sel_a];
    assign agree_b = u_chan_b.sync2[sel_b] == u_chan_b.sync3[sel_b];
    assign lvl_a   = u_chan_a.sync3[sel_a] ~^ ext_irq_config[`EIP_A_POL_BIT];
    assign lvl_b   = u_chan_b.sync3[sel_b] ~^ ext_irq_config[`EIP_B_POL_BIT];

    property p_level_pin_a;
        @(posedge i_clock) disable iff (i_rst)
        (!i_irq_a_edge_sel && agree_a) |=> pend_a == $past(lvl_a);
    endproperty
    a_level_pin_a: assert property (p_level_pin_a) else $error("first pin level wrong");

    property p_level_pin_b;
        @(posedge i_clock) disable iff (i_rst)
        (!i_irq_b_edge_sel && agree_b) |=> pend_b == $past(lvl_b);
    endproperty
    a_level_pin_b: assert property (p_level_pin_b) else $error("second pin level wrong");

    sequence s_rise_b;
        i_irq_b_edge_sel && u_chan_b.active && !u_chan_b.act_prev;
    endsequence
    property p_edge_set_b;
        @(posedge i_clock) disable iff (i_rst) s_rise_b |=> pend_b ##1 o_irq_b_pending;
    endproperty
    a_edge_set_b: assert property (p_edge_set_b) else $error("second edge not latched");

    property p_set_wins_a;
        @(posedge i_clock) disable iff (i_rst) (s_rise_a ##0 i_irq_a_vector) |=> pend_a;
    endproperty
    a_set_wins_a: assert property (p_set_wins_a) else $error("first edge lost to vector");

    property p_set_wins_b;
        @(posedge i_clock) disable iff (i_rst) (s_rise_b ##0 i_irq_b_vector) |=> pend_b;
    endproperty
    a_set_wins_b: assert property (p_set_wins_b) else $error("second edge lost to vector");

    property p_vector_clr_b;
        @(posedge i_clock) disable iff (i_rst)
        (i_irq_b_edge_sel && i_irq_b_vector && !(u_chan_b.active && !u_chan_b.act_prev)) |=> !pend_b;
    endproperty
    a_vector_clr_b: assert property (p_vector_clr_b) else $error("second vector clear failed");

    property p_edge_hold_b;
        @(posedge i_clock) disable iff (i_rst)
        (i_irq_b_edge_sel && pend_b && !i_irq_b_vector) |=> pend_b;
    endproperty
    a_edge_hold_b: assert property (p_edge_hold_b) else $error("second edge pending dropped");

    property p_out_follow_a;
        @(posedge i_clock) disable iff (i_rst) 1'b1 |=> o_irq_a_pending == $past(pend_a);
    endproperty
    a_out_follow_a: assert property (p_out_follow_a) else $error("first request not pending");
endmodule // eip_top

// File: inc/eip_consts.svh
// Constants for the external interrupt pair: register offset, fields, resets.
// Included by the package user files; definitions only.
`ifndef EIP_CONSTS_SVH
`define EIP_CONSTS_SVH
`define EIP_CFG_ADDR      8'he4
`define EIP_CFG_RESET     8'h01
`define EIP_A_SEL_LSB     0
`define EIP_A_SEL_MSB     2
`define EIP_A_POL_BIT     3
`define EIP_B_SEL_LSB     4
`define EIP_B_SEL_MSB     6
`define EIP_B_POL_BIT     7
`define EIP_SYNC_STAGES   3
`endif

// File: inc/eip_pkg.sv
// Types for the external interrupt pair.
// Assumes nothing beyond the constants header.
package eip_pkg;
    // Sensing mode of one input
    typedef enum logic {EIP_LEVEL, EIP_EDGE} eip_sense_t;
    // Pin select code
    typedef logic [2:0] eip_sel_t;
endpackage

// File: rtl/eip_channel.sv
// One external interrupt channel: pin select, sync, polarity, pending flag.
// Assumes port 0 pins are asynchronous and vector acks are one-cycle pulses.
`timescale 1ns/10ps
`include "eip_consts.svh"
module eip_channel
    import eip_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // Configuration
    input  wire logic [7:0] i_port0,
    input  wire eip_sel_t   i_pin_sel,
    input  wire logic       i_polarity,
    input  wire logic       i_edge_sel,
    input  wire logic       i_vector_ack,
    // Result
    output logic            o_pending
);
    // Sync chain for all eight pins; selecting after sync keeps select changes glitch free
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;
    logic       act_prev;   // Edge history, inactive after reset
    logic       active;     // Agreed, polarity-corrected level

    // observe only
    // Three flops per pin; pins are only read, never driven.
    // No reset on the chain: it fills from the pins while reset is held (three edges at least),
    // so a cleared chain cannot fake an active-low level and a false edge after reset.
    always_ff @(posedge i_clock) begin
        sync1 <= i_port0;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // agreed synchronised level
    // Change counts once stages two and three agree; else hold previous
    logic raw_lvl;
    always_comb begin
        raw_lvl = (sync2[i_pin_sel] == sync3[i_pin_sel]) ? sync2[i_pin_sel]
                                                          : (act_prev ~^ i_polarity);
    end
    assign active = i_polarity ? raw_lvl : ~raw_lvl;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            act_prev <= 1'b0;
        end else begin
            act_prev <= active;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_pending <= 1'b0;
        end else if (i_edge_sel) begin
            // edge sets pending; set wins over vector clear
            if (active && !act_prev) begin
                o_pending <= 1'b1;
            end else if (i_vector_ack) begin
                o_pending <= 1'b0;
            end
        end else begin
            o_pending <= active;
        end
    end
endmodule // eip_channel

// File: sim/eip_src.sv
// Partner model: external sources that drive the port 0 pins.
// Assumes the bench sets the wanted levels; the pins follow on the clock.
`timescale 1ns/10ps
module eip_src (
    // Clock and wanted levels
    input  wire logic       i_clock,
    input  wire logic [7:0] i_want,
    // Port 0 pins
    output logic [7:0]      o_port0
);
    // pins interrupt-only
    // Nothing but these sources drives port 0, as if the crossbar skipped the pins
    // hold, then release
    // The bench keeps a level until it has checked the flag, save the first edge pulse, which pending latches, so no request is dropped
    always_ff @(posedge i_clock) begin
        o_port0 <= i_want;
    end
endmodule // eip_src

// File: sim/external_interrupt_pair_bench.sv
// Bench for the interrupt pair: register, level and edge cases.
// Assumes the package and the source model compile first.
`timescale 1ns/10ps
module external_interrupt_pair_bench;
    import eip_pkg::*;
    logic       i_clock   = 1'b0;  // 50 ns clock
    logic       i_rst     = 1'b1;  // Sync reset
    logic [7:0] addr      = 8'h00; // Register address
    logic       wr        = 1'b0;  // Write strobe
    logic [7:0] wdata     = 8'h00; // Write data
    logic       edge_a    = 1'b0;  // Sense selects
    logic       edge_b    = 1'b0;
    logic       vec_a     = 1'b0;  // Vector pulses
    logic       vec_b     = 1'b0;
    logic [7:0] want      = 8'h00; // Wanted pin levels
    logic [7:0] port0;             // Pins
    logic [7:0] rdata;             // Read data
    logic       pend_a;            // Pending flags
    logic       pend_b;
    int         error_cnt = 0;
    int         n_checks  = 0;

    eip_src src_u (.i_clock(i_clock), .i_want(want), .o_port0(port0));
    eip_top dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
        .i_irq_a_edge_sel(edge_a), .i_irq_b_edge_sel(edge_b), .i_irq_a_vector(vec_a),
        .i_irq_b_vector(vec_b), .i_port0(port0), .o_reg_rdata(rdata), .o_irq_a_pending(pend_a),
        .o_irq_b_pending(pend_b));

    // Clock
    initial begin
        forever #25 i_clock = ~i_clock;
    end

    // Compare and count
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask

    // Flags sampled mid cycle, where they are settled
    task automatic chk_pend(input logic ea, input logic eb);
        @(negedge i_clock);
        chk("pend_a", {7'h00, pend_a}, {7'h00, ea});
        chk("pend_b", {7'h00, pend_b}, {7'h00, eb});
    endtask

    // One write strobe, dropped at the next edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clock);
        addr  <= a;
        wr    <= 1'b1;
        wdata <= v;
        @(posedge i_clock);
        wr    <= 1'b0;
    endtask

    // Read answers one cycle after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clock);
        addr <= a;
        tick(1);
        @(negedge i_clock);
        chk("rdata", rdata, exp);
    endtask

    task automatic t_regs;
        rd(8'he4, 8'h01);
        rd(8'h5a, 8'h00);
        wr_reg(8'h5a, 8'h77);
        wr_reg(8'he4, 8'ha5);
        rd(8'he4, 8'ha5);
        $display("regs done");
    endtask

    // Every pin code on both inputs, other pins held opposite
    task automatic t_level;
        for (int c = 0; c < 8; c++) begin
            wr_reg(8'he4, {1'b1, c[2:0], 1'b1, c[2:0]});
            @(posedge i_clock) want <= ~(8'h01 << c);
            tick(7);
            chk_pend(1'b0, 1'b0);
            @(posedge i_clock) want <= 8'h01 << c;
            tick(7);
            chk_pend(1'b1, 1'b1);
        end
        // Active low, and a vector pulse is ignored
        wr_reg(8'he4, 8'h00);
        @(posedge i_clock) want <= 8'hfe;
        tick(7);
        @(posedge i_clock) vec_a <= 1'b1;
        @(posedge i_clock) vec_a <= 1'b0;
        tick(3);
        chk_pend(1'b1, 1'b1);
        $display("level done");
    endtask

    // First input low edge on pin 2, second high edge on pin 5
    task automatic t_edge;
        wr_reg(8'he4, 8'hd2);
        // Settle both pins inactive in level mode first; edge mode keeps an old flag
        @(posedge i_clock) want <= 8'h04;
        tick(7);
        @(posedge i_clock);
        edge_a <= 1'b1;
        edge_b <= 1'b1;
        tick(2);
        chk_pend(1'b0, 1'b0);
        @(posedge i_clock) want <= 8'h20;
        tick(7);
        @(posedge i_clock) want <= 8'h04;
        tick(7);
        chk_pend(1'b1, 1'b1);
        @(posedge i_clock) vec_a <= 1'b1;
        @(posedge i_clock) vec_a <= 1'b0;
        tick(2);
        chk_pend(1'b0, 1'b1);
        @(posedge i_clock) vec_b <= 1'b1;
        @(posedge i_clock) vec_b <= 1'b0;
        tick(2);
        chk_pend(1'b0, 1'b0);
        // Vectors land in the cycle the new edges are seen: the set wins
        @(posedge i_clock) want <= 8'h20;
        tick(3);
        @(posedge i_clock);
        vec_a <= 1'b1;
        vec_b <= 1'b1;
        @(posedge i_clock);
        vec_a <= 1'b0;
        vec_b <= 1'b0;
        tick(2);
        chk_pend(1'b1, 1'b1);
        $display("edge done");
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        tick(8);
        i_rst <= 1'b0;
        t_regs;
        t_level;
        t_edge;
        conclude;
    end
endmodule // external_interrupt_pair_bench
